// ---- hw/multifunction_pin_mux.sv ----
`timescale 1ns/1ps
`default_nettype none
module multifunction_pin_mux (
	input  wire logic       ref_clk,          // Register clock
	input  wire logic       reset_n,          // Async reset
	input  wire logic       reg_wr,           // Write strobe
	input  wire logic       reg_rd,           // Read strobe
	input  wire logic [7:0] reg_addr,         // Register address
	input  wire logic [7:0] reg_wdata,        // Write data
	output logic      [7:0] reg_rdata,        // Read data
	input  wire logic       spi_mode,         // Control port in peripheral mode
	input  wire logic       spi_data_out,     // Peripheral data level
	input  wire logic       spi_data_oe,      // Peripheral data driven
	input  wire logic       irq_level,        // Function sources
	input  wire logic       pdm_clock_output,
	input  wire logic       pri_dout,
	input  wire logic       pri_second_data_output,
	input  wire logic       sec_dout,
	input  wire logic       sec_second_data_output,
	input  wire logic       sec_bitclk,
	input  wire logic       sec_framesync,
	input  wire logic       general_clock_output,
	input  wire logic       muxed_dout,
	input  wire logic       chain_out,
	input  wire logic       bidir_pin_a_in,   // Pin inputs
	input  wire logic       in_pin_c,
	input  wire logic       in_pin_d,
	input  wire logic       serial_out_in,
	input  wire logic       pri_din_pin,
	input  wire logic       bitclk_pin,
	input  wire logic       framesync_pin,
	output logic            bidir_pin_a_out,  // Bidir pad
	output logic            bidir_pin_a_oe_n,
	output logic            bidir_pin_a_pull_up,
	output logic            bidir_pin_a_pull_dn,
	output logic            out_pin_b_out,    // Output pad
	output logic            out_pin_b_oe_n,
	output logic            out_pin_b_pull_up,
	output logic            out_pin_b_pull_dn,
	output logic            out_pin_b_keeper_en,
	output logic            serial_out_out,   // Serial out pad
	output logic            serial_out_oe_n,
	output logic            serial_out_pull_up,
	output logic            serial_out_pull_dn,
	output logic            ctrl_clk,         // Routed sources
	output logic            primary_second_in,
	output logic            primary_bitclk,
	output logic            primary_framesync
);
	localparam int NSYNC = 7;
	localparam logic [2:0] HOLD_LAST = 3'(pin_mux_pkg::OUT_B_HOLD - 1);

	// Register bank state
	logic [7:0] page_r, page_nxt;
	logic [7:0] bidir_cfg_r, bidir_cfg_nxt;
	logic [7:0] outb_cfg_r, outb_cfg_nxt;
	logic [7:0] inen_r, inen_nxt;
	logic [7:0] val_r, val_nxt;
	logic [7:0] src_r, src_nxt;
	logic [7:0] so_cfg_r, so_cfg_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic       page_ok;                      // Pin page selected
	logic       sw_reset;                     // Self-clearing reset write

	// Synchroniser chain
	logic [NSYNC-1:0] sync1_r, sync2_r;
	logic [NSYNC-1:0] raw_in;
	logic a_s, c_s, d_s, so_s, din_s, bclk_s, fsync_s;

	// Decoded fields
	logic [3:0] a_fn, b_fn, so_fn;
	logic       a_in, c_in, d_in, so_in;      // Gated input levels
	logic [2:0] mon;

	// Function and drive results
	logic a_lvl, a_drv, a_aud, b_lvl, b_drv, b_aud, so_lvl, so_drv, so_aud;
	logic b_lvl_sel, b_drv_sel;
	logic a_po, a_poe, a_pu, a_pd, b_po, b_poe, b_pu, b_pd, s_po, s_poe, s_pu, s_pd;

	// Pad and routing outputs
	logic [3:0] a_pad_r, a_pad_nxt, b_pad_r, b_pad_nxt, s_pad_r, s_pad_nxt;
	logic       keep_r, keep_nxt;
	logic [3:0] route_r, route_nxt;
	logic [2:0] hold_r, hold_nxt;             // Output pin toggle spacing
	logic       live_r;                       // High from the first edge after reset release

	assign raw_in = {framesync_pin, bitclk_pin, pri_din_pin, serial_out_in, in_pin_d, in_pin_c, bidir_pin_a_in};

	// Two flops per pin; only the second stage is read
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge ref_clk or negedge reset_n) begin
				if (!reset_n) begin
					sync1_r[gi] <= 1'b0;
					sync2_r[gi] <= 1'b0;
				end else begin
					sync1_r[gi] <= raw_in[gi];
					sync2_r[gi] <= sync1_r[gi];
				end
			end
		end
	endgenerate
	assign {fsync_s, bclk_s, din_s, so_s, d_s, c_s, a_s} = sync2_r;

	assign a_fn  = bidir_cfg_r[pin_mux_pkg::FN_LSB +: 4];
	assign b_fn  = outb_cfg_r[pin_mux_pkg::FN_LSB +: 4];
	assign so_fn = so_cfg_r[pin_mux_pkg::FN_LSB +: 4];

	// Inputs count only when the pin is set as an input
	assign a_in  = a_s & (a_fn == pin_mux_pkg::FN_IN);
	assign c_in  = c_s & inen_r[pin_mux_pkg::IN_C_BIT];
	assign d_in  = d_s & inen_r[pin_mux_pkg::IN_D_BIT];
	assign so_in = so_s & (so_fn == pin_mux_pkg::FN_IN);
	assign mon   = {a_in, d_in, c_in};

	// Page gate; page register itself is always reachable
	assign page_ok  = (page_r == pin_mux_pkg::PAGE_PINS);
	assign sw_reset = reg_wr && page_ok && (reg_addr == pin_mux_pkg::ADDR_SWRST)
		&& reg_wdata[pin_mux_pkg::SWRST_BIT];

	// Register writes, software reset and read decode
	always_comb begin
		page_nxt      = page_r;
		bidir_cfg_nxt = bidir_cfg_r;
		outb_cfg_nxt  = outb_cfg_r;
		inen_nxt      = inen_r;
		val_nxt       = val_r;
		src_nxt       = src_r;
		so_cfg_nxt    = so_cfg_r;
		rdata_nxt     = rdata_r;
		if (sw_reset) begin
			// Every config register back to power-on values; read data register is not reset
			page_nxt      = pin_mux_pkg::RST_PAGE;
			bidir_cfg_nxt = pin_mux_pkg::RST_BIDIR;
			outb_cfg_nxt  = pin_mux_pkg::RST_OUTB;
			inen_nxt      = pin_mux_pkg::RST_INEN;
			val_nxt       = pin_mux_pkg::RST_VAL;
			src_nxt       = pin_mux_pkg::RST_SRC;
			so_cfg_nxt    = pin_mux_pkg::RST_SO;
		end else if (reg_wr) begin
			if (reg_addr == pin_mux_pkg::ADDR_PAGE) begin
				page_nxt = reg_wdata;
			end else if (page_ok) begin
				case (reg_addr)
					pin_mux_pkg::ADDR_BIDIR: bidir_cfg_nxt = reg_wdata & pin_mux_pkg::WMASK_BIDIR;
					pin_mux_pkg::ADDR_OUTB:  outb_cfg_nxt  = reg_wdata & pin_mux_pkg::WMASK_OUTB;
					pin_mux_pkg::ADDR_INEN:  inen_nxt      = reg_wdata & pin_mux_pkg::WMASK_INEN;
					pin_mux_pkg::ADDR_VAL:   val_nxt       = reg_wdata & pin_mux_pkg::WMASK_VAL;
					pin_mux_pkg::ADDR_SRC:   src_nxt       = reg_wdata & pin_mux_pkg::WMASK_SRC;
					pin_mux_pkg::ADDR_SO:    so_cfg_nxt    = reg_wdata & pin_mux_pkg::WMASK_SO;
					default:                 page_nxt      = page_r;
				endcase
			end
		end
		if (reg_rd) begin
			// Unmapped addresses read zero; other pages read zero except the page register
			rdata_nxt = 8'h00;
			if (reg_addr == pin_mux_pkg::ADDR_PAGE) begin
				rdata_nxt = page_r;
			end else if (page_ok) begin
				case (reg_addr)
					pin_mux_pkg::ADDR_BIDIR: rdata_nxt = bidir_cfg_r;
					pin_mux_pkg::ADDR_OUTB:  rdata_nxt = outb_cfg_r;
					pin_mux_pkg::ADDR_INEN:  rdata_nxt = inen_r;
					pin_mux_pkg::ADDR_VAL:   rdata_nxt = val_r | {4'h0, mon, 1'b0};
					pin_mux_pkg::ADDR_SRC:   rdata_nxt = src_r;
					pin_mux_pkg::ADDR_SO:    rdata_nxt = so_cfg_r;
					default:                 rdata_nxt = 8'h00;  // Reset bit self-clears
				endcase
			end
		end
	end

	// Register bank flops
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			page_r      <= pin_mux_pkg::RST_PAGE;
			bidir_cfg_r <= pin_mux_pkg::RST_BIDIR;
			outb_cfg_r  <= pin_mux_pkg::RST_OUTB;
			inen_r      <= pin_mux_pkg::RST_INEN;
			val_r       <= pin_mux_pkg::RST_VAL;
			src_r       <= pin_mux_pkg::RST_SRC;
			so_cfg_r    <= pin_mux_pkg::RST_SO;
			rdata_r     <= 8'h00;
		end else begin
			page_r      <= page_nxt;
			bidir_cfg_r <= bidir_cfg_nxt;
			outb_cfg_r  <= outb_cfg_nxt;
			inen_r      <= inen_nxt;
			val_r       <= val_nxt;
			src_r       <= src_nxt;
			so_cfg_r    <= so_cfg_nxt;
			rdata_r     <= rdata_nxt;
		end
	end
	assign reg_rdata = rdata_r;

	// Function selection per pin; reserved codes never drive
	pin_func_sel #(.VALID_MASK(pin_mux_pkg::FN_VALID)) u_fn_a (
		.fn_code (a_fn),
		.src     ({2'b00, chain_out, muxed_dout, general_clock_output, sec_framesync, sec_bitclk,
			sec_second_data_output, sec_dout, pri_second_data_output, pri_dout, pdm_clock_output,
			irq_level, val_r[pin_mux_pkg::A_VAL_BIT], 2'b00}),
		.level   (a_lvl),
		.drives  (a_drv),
		.audio   (a_aud)
	);
	pin_func_sel #(.VALID_MASK(pin_mux_pkg::FN_VALID)) u_fn_b (
		.fn_code (b_fn),
		.src     ({2'b00, chain_out, muxed_dout, general_clock_output, sec_framesync, sec_bitclk,
			sec_second_data_output, sec_dout, pri_second_data_output, pri_dout, pdm_clock_output,
			irq_level, val_r[pin_mux_pkg::B_VAL_BIT], 2'b00}),
		.level   (b_lvl),
		.drives  (b_drv),
		.audio   (b_aud)
	);
	// Code 13 on the serial out pin loops the data input back
	pin_func_sel #(.VALID_MASK(pin_mux_pkg::FN_VALID)) u_fn_so (
		.fn_code (so_fn),
		.src     ({2'b00, din_s, muxed_dout, general_clock_output, sec_framesync, sec_bitclk,
			sec_second_data_output, sec_dout, pri_second_data_output, pri_dout, pdm_clock_output,
			irq_level, so_cfg_r[pin_mux_pkg::SO_VAL_BIT], 2'b00}),
		.level   (so_lvl),
		.drives  (so_drv),
		.audio   (so_aud)
	);

	// Peripheral mode takes over the output pin
	assign b_lvl_sel = spi_mode ? spi_data_out : b_lvl;
	assign b_drv_sel = spi_mode ? spi_data_oe : b_drv;

	// Audio roles are push-pull whatever the style field says
	pin_drive u_drv_a (
		.drv_code (bidir_cfg_r[pin_mux_pkg::DRV_LSB +: 3]),
		.level    (a_lvl),
		.drives   (a_drv),
		.force_pp (a_aud),
		.pad_out  (a_po),
		.pad_oe_n (a_poe),
		.pull_up  (a_pu),
		.pull_dn  (a_pd)
	);
	pin_drive u_drv_b (
		.drv_code (outb_cfg_r[pin_mux_pkg::DRV_LSB +: 3]),
		.level    (b_pad_r[3]),
		.drives   (b_drv_sel),
		.force_pp (spi_mode | b_aud),
		.pad_out  (b_po),
		.pad_oe_n (b_poe),
		.pull_up  (b_pu),
		.pull_dn  (b_pd)
	);
	pin_drive u_drv_so (
		.drv_code (so_cfg_r[pin_mux_pkg::DRV_LSB +: 3]),
		.level    (so_lvl),
		.drives   (so_drv),
		.force_pp (so_aud),
		.pad_out  (s_po),
		.pad_oe_n (s_poe),
		.pull_up  (s_pu),
		.pull_dn  (s_pd)
	);

	// Pad and routing next values
	always_comb begin
		a_pad_nxt = {a_po, a_poe, a_pu, a_pd};
		s_pad_nxt = {s_po, s_poe, s_pu, s_pd};
		// Level held at least the hold span, limiting toggle rate
		hold_nxt  = (hold_r != 3'h0) ? hold_r - 3'h1 : 3'h0;
		b_pad_nxt = {b_pad_r[3], b_poe, b_pu, b_pd};
		if ((hold_r == 3'h0) && (b_lvl_sel != b_pad_r[3])) begin
			b_pad_nxt[3] = b_lvl_sel;
			hold_nxt     = HOLD_LAST;
		end
		// Keeper only on an idle, non-audio pin
		keep_nxt  = ~spi_mode & ~b_aud & ~b_drv;
		route_nxt[3] = 1'b0;
		case (src_r[pin_mux_pkg::CCLK_LSB +: 2])
			pin_mux_pkg::CCLK_A: route_nxt[3] = a_in;
			pin_mux_pkg::CCLK_D: route_nxt[3] = d_in;
			pin_mux_pkg::CCLK_C: route_nxt[3] = c_in;
			default:             route_nxt[3] = 1'b0;
		endcase
		case (src_r[pin_mux_pkg::SECOND_DATA_INPUT_LSB +: 3])
			pin_mux_pkg::SECOND_DATA_INPUT_A:   route_nxt[2] = a_in;
			pin_mux_pkg::SECOND_DATA_INPUT_D:   route_nxt[2] = d_in;
			pin_mux_pkg::SECOND_DATA_INPUT_C:   route_nxt[2] = c_in;
			pin_mux_pkg::SECOND_DATA_INPUT_SO:  route_nxt[2] = so_in;
			pin_mux_pkg::SECOND_DATA_INPUT_DIN: route_nxt[2] = din_s;
			default:               route_nxt[2] = 1'b0;
		endcase
		route_nxt[1] = src_r[pin_mux_pkg::BCLK_BIT] ? sec_bitclk : bclk_s;
		route_nxt[0] = src_r[pin_mux_pkg::FSYNC_BIT] ? sec_framesync : fsync_s;
	end

	// Pad and routing flops; pads idle at high impedance
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			a_pad_r <= 4'h4;
			b_pad_r <= 4'h4;
			s_pad_r <= 4'h4;
			keep_r  <= 1'b0;
			route_r <= 4'h0;
			hold_r  <= 3'h0;
			live_r  <= 1'b0;
		end else begin
			a_pad_r <= a_pad_nxt;
			b_pad_r <= b_pad_nxt;
			s_pad_r <= s_pad_nxt;
			keep_r  <= keep_nxt;
			route_r <= route_nxt;
			hold_r  <= hold_nxt;
			live_r  <= 1'b1;
		end
	end
	assign {bidir_pin_a_out, bidir_pin_a_oe_n, bidir_pin_a_pull_up, bidir_pin_a_pull_dn} = a_pad_r;
	assign {out_pin_b_out, out_pin_b_oe_n, out_pin_b_pull_up, out_pin_b_pull_dn} = b_pad_r;
	assign {serial_out_out, serial_out_oe_n, serial_out_pull_up, serial_out_pull_dn} = s_pad_r;
	assign out_pin_b_keeper_en = keep_r;
	assign {ctrl_clk, primary_second_in, primary_bitclk, primary_framesync} = route_r;

	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	// Release edge still samples reset-state pads, so checks wait one edge
	default disable iff (!reset_n || !live_r);

	sequence sw_reset_req;
		reg_wr && page_ok && (reg_addr == pin_mux_pkg::ADDR_SWRST) && reg_wdata[0];
	endsequence
	sequence blocked_cfg_write;
		reg_wr && !page_ok && (reg_addr == pin_mux_pkg::ADDR_BIDIR);
	endsequence

	AST_SW_RESET: assert property (sw_reset_req |=> (bidir_cfg_r == 8'h32) && (so_cfg_r == 8'h52)
		&& (page_r == 8'h00)) else $error("software reset missed defaults");
	AST_PAGE_GATE: assert property (blocked_cfg_write |=> $stable(bidir_cfg_r))
		else $error("write landed off page zero");
	AST_RSVD_HIZ: assert property (a_fn >= 4'he |=> bidir_pin_a_oe_n && !bidir_pin_a_pull_up)
		else $error("reserved code drove bidir pin");
	AST_GPO_LEVEL: assert property ((a_fn == 4'h2) && (bidir_cfg_r[2:0] == 3'h1)
		|=> !bidir_pin_a_oe_n && (bidir_pin_a_out == $past(val_r[7])))
		else $error("general output level wrong");
	AST_AUDIO_PP: assert property ((so_fn == 4'h5) |=> !serial_out_oe_n && (serial_out_out == $past(pri_dout)))
		else $error("audio role not push-pull");
	AST_SPI_OWN: assert property (spi_mode && spi_data_oe |=> !out_pin_b_oe_n)
		else $error("peripheral data not driven");
	AST_NO_KEEPER: assert property (b_aud |=> !out_pin_b_keeper_en)
		else $error("keeper on audio pin");
	AST_TOGGLE_GAP: assert property ($changed(out_pin_b_out) |=> $stable(out_pin_b_out)[*3])
		else $error("output pin toggled too fast");
	AST_MON_GATED: assert property (reg_rd && page_ok && (reg_addr == 8'h0e) && !inen_r[1]
		|=> !reg_rdata[1]) else $error("disabled input shown in monitor");
	AST_CCLK_OFF: assert property (src_r[6:5] == 2'h0 |=> !ctrl_clk)
		else $error("controller clock not disabled");
	AST_SYNC_DELAY: assert property (##2 (sync2_r[0] == $past(bidir_pin_a_in, 2)))
		else $error("input not two flops deep");

endmodule : multifunction_pin_mux
`default_nettype wire

// ---- hw/pin_mux_pkg.sv ----
package pin_mux_pkg;

	// Register addresses in the paged control space
	localparam logic [7:0] ADDR_PAGE   = 8'h00;
	localparam logic [7:0] ADDR_SWRST  = 8'h01;
	localparam logic [7:0] ADDR_BIDIR  = 8'h0a;
	localparam logic [7:0] ADDR_OUTB   = 8'h0c;
	localparam logic [7:0] ADDR_INEN   = 8'h0d;
	localparam logic [7:0] ADDR_VAL    = 8'h0e;
	localparam logic [7:0] ADDR_SRC    = 8'h0f;
	localparam logic [7:0] ADDR_SO     = 8'h10;
	localparam logic [7:0] PAGE_PINS   = 8'h00;

	// Reset values
	localparam logic [7:0] RST_PAGE    = 8'h00;
	localparam logic [7:0] RST_BIDIR   = 8'h32;
	localparam logic [7:0] RST_OUTB    = 8'h00;
	localparam logic [7:0] RST_INEN    = 8'h00;
	localparam logic [7:0] RST_VAL     = 8'h00;
	localparam logic [7:0] RST_SRC     = 8'h00;
	localparam logic [7:0] RST_SO      = 8'h52;

	// Writable bits; reserved bits stay zero
	localparam logic [7:0] WMASK_BIDIR = 8'hf7;
	localparam logic [7:0] WMASK_OUTB  = 8'hff;
	localparam logic [7:0] WMASK_INEN  = 8'h03;
	localparam logic [7:0] WMASK_VAL   = 8'ha0;
	localparam logic [7:0] WMASK_SRC   = 8'h7f;
	localparam logic [7:0] WMASK_SO    = 8'hff;

	// Field positions
	localparam int FN_LSB      = 4;
	localparam int DRV_LSB     = 0;
	localparam int SWRST_BIT   = 0;
	localparam int IN_C_BIT    = 1;
	localparam int IN_D_BIT    = 0;
	localparam int A_VAL_BIT   = 7;
	localparam int B_VAL_BIT   = 5;
	localparam int A_MON_BIT   = 3;
	localparam int D_MON_BIT   = 2;
	localparam int C_MON_BIT   = 1;
	localparam int CCLK_LSB    = 5;
	localparam int SECOND_DATA_INPUT_LSB    = 2;
	localparam int BCLK_BIT    = 1;
	localparam int FSYNC_BIT   = 0;
	localparam int SO_VAL_BIT  = 3;

	// Shared pin function codes
	typedef enum logic [3:0] {
		FN_OFF = 4'h0, FN_IN = 4'h1, FN_GPO = 4'h2, FN_IRQ = 4'h3,
		FN_PDM_CLOCK_OUTPUT = 4'h4, FN_PRI_DOUT = 4'h5, FN_PRI_SECOND_DATA_OUTPUT = 4'h6,
		FN_SEC_DOUT = 4'h7, FN_SEC_SECOND_DATA_OUTPUT = 4'h8, FN_SEC_BCLK = 4'h9,
		FN_SEC_FSYNC = 4'ha, FN_GENERAL_CLOCK_OUTPUT = 4'hb, FN_MUXED = 4'hc, FN_CHAIN = 4'hd
	} fn_t;
	localparam logic [15:0] FN_VALID   = 16'h3fff;
	localparam logic [15:0] FN_AUDIO   = 16'h31e0;

	// Drive style codes
	typedef enum logic [2:0] {
		DRV_HIZ = 3'h0, DRV_PUSHPULL = 3'h1, DRV_LOW_WEAKHI = 3'h2,
		DRV_LOW_ONLY = 3'h3, DRV_WEAKLO_HI = 3'h4, DRV_HI_ONLY = 3'h5
	} drv_t;

	// Source select codes
	localparam logic [1:0] CCLK_OFF  = 2'h0;
	localparam logic [1:0] CCLK_A    = 2'h1;
	localparam logic [1:0] CCLK_D    = 2'h2;
	localparam logic [1:0] CCLK_C    = 2'h3;
	localparam logic [2:0] SECOND_DATA_INPUT_A    = 3'h1;
	localparam logic [2:0] SECOND_DATA_INPUT_D    = 3'h2;
	localparam logic [2:0] SECOND_DATA_INPUT_C    = 3'h3;
	localparam logic [2:0] SECOND_DATA_INPUT_SO   = 3'h4;
	localparam logic [2:0] SECOND_DATA_INPUT_DIN  = 3'h5;

	// Timing: output pin toggle limit
	localparam int REF_CLK_HZ  = 40_000_000;
	localparam int OUT_B_MAX_HZ = 6_000_000;
	localparam int OUT_B_HOLD  = (REF_CLK_HZ + 2 * OUT_B_MAX_HZ - 1) / (2 * OUT_B_MAX_HZ);
	localparam int SYNC_STAGES = 2;

endpackage : pin_mux_pkg

// ---- hw/pin_func_sel.sv ----
`timescale 1ns/1ps
`default_nettype none
// Decodes a function code into a level and drive request
module pin_func_sel #(
	parameter logic [15:0] VALID_MASK = pin_mux_pkg::FN_VALID
) (
	input  wire logic [3:0]  fn_code,    // Function field
	input  wire logic [15:0] src,        // Level per function code
	output logic             level,      // Selected level
	output logic             drives,     // Pin is an output
	output logic             audio       // Pin carries serial audio
);
	// Reserved codes and input codes never drive
	always_comb begin
		level  = src[fn_code];
		drives = VALID_MASK[fn_code] && (fn_code >= pin_mux_pkg::FN_GPO);
		audio  = VALID_MASK[fn_code] && pin_mux_pkg::FN_AUDIO[fn_code];
	end
endmodule : pin_func_sel
`default_nettype wire

// ---- hw/pin_drive.sv ----
`timescale 1ns/1ps
`default_nettype none
// Turns a level and drive style into pad controls
module pin_drive (
	input  wire logic [2:0] drv_code,   // Drive style field
	input  wire logic       level,      // Wanted level
	input  wire logic       drives,     // Output requested
	input  wire logic       force_pp,   // Ignore style, push-pull
	output logic            pad_out,    // Strong driver level
	output logic            pad_oe_n,   // Strong driver enable, low drives
	output logic            pull_up,    // Weak high
	output logic            pull_dn     // Weak low
);
	// Style table; reserved codes fall to high impedance
	always_comb begin
		pad_out  = level;
		pad_oe_n = 1'b1;
		pull_up  = 1'b0;
		pull_dn  = 1'b0;
		if (drives) begin
			if (force_pp) begin
				pad_oe_n = 1'b0;
			end else begin
				case (drv_code)
					pin_mux_pkg::DRV_PUSHPULL:   pad_oe_n = 1'b0;
					pin_mux_pkg::DRV_LOW_WEAKHI: begin
						pull_up  = level;
						pad_oe_n = level;
					end
					pin_mux_pkg::DRV_LOW_ONLY:   pad_oe_n = level;
					pin_mux_pkg::DRV_WEAKLO_HI: begin
						pull_dn  = ~level;
						pad_oe_n = ~level;
					end
					pin_mux_pkg::DRV_HI_ONLY:    pad_oe_n = ~level;
					default:                     pad_oe_n = 1'b1;
				endcase
			end
		end
	end
endmodule : pin_drive
`default_nettype wire

// ---- testbench/pin_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
// Far side of one pad: external driver, weak pulls, floating wire
module pin_partner (
	input  wire logic ref_clk, // Register clock
	input  wire logic o,       // Pad level
	input  wire logic oe_n,    // Pad enable, low drives
	input  wire logic pu,      // Weak high
	input  wire logic pd,      // Weak low
	input  wire logic en,      // Far side drives
	input  wire logic lvl,     // Far side level
	output logic      pin      // Resolved wire
);
	logic last_r = 1'h0; // Last wire level
	// Floating wire flips each cycle so no lucky value passes
	always_ff @(posedge ref_clk) last_r <= pin;
	// Strong pad wins, then far driver, then weak pulls
	always_comb begin
		if (!oe_n) pin = o;
		else if (en) pin = lvl;
		else if (pu) pin = 1'h1;
		else if (pd) pin = 1'h0;
		else pin = ~last_r;
	end
endmodule : pin_partner
`default_nettype wire

// ---- testbench/multifunction_pin_mux_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module multifunction_pin_mux_test;
	logic ref_clk, reset_n, reg_wr, reg_rd, spi_mode, spi_data_out, spi_data_oe, a_en, a_lvl, s_en, s_lvl;
	logic irq_level, pdm_clock_output, pri_dout, pri_second_data_output, sec_dout, sec_second_data_output;
	logic sec_bitclk, sec_framesync, general_clock_output, muxed_dout, chain_out, in_pin_c, in_pin_d;
	logic bidir_pin_a_in, serial_out_in, pri_din_pin, bitclk_pin, framesync_pin, ctrl_clk, primary_second_in;
	logic bidir_pin_a_out, bidir_pin_a_oe_n, bidir_pin_a_pull_up, bidir_pin_a_pull_dn, primary_bitclk;
	logic out_pin_b_out, out_pin_b_oe_n, out_pin_b_pull_up, out_pin_b_pull_dn, out_pin_b_keeper_en;
	logic serial_out_out, serial_out_oe_n, serial_out_pull_up, serial_out_pull_dn, primary_framesync;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	logic [7:0] drv_oe [2] = '{8'hf1, 8'hcd};        // Expected oe_n per drive code, level 0 then 1
	logic [7:0] rst_ad [6] = '{8'h0a, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10};
	logic [7:0] rst_v [6]  = '{8'h32, 8'h00, 8'h00, 8'h00, 8'h00, 8'h52};
	int         failures, tests_run;

	multifunction_pin_mux uut (.*);
	pin_partner bidir_side (.ref_clk, .o(bidir_pin_a_out), .oe_n(bidir_pin_a_oe_n), .pu(bidir_pin_a_pull_up),
		.pd(bidir_pin_a_pull_dn), .en(a_en), .lvl(a_lvl), .pin(bidir_pin_a_in));
	pin_partner sout_side (.ref_clk, .o(serial_out_out), .oe_n(serial_out_oe_n), .pu(serial_out_pull_up),
		.pd(serial_out_pull_dn), .en(s_en), .lvl(s_lvl), .pin(serial_out_in));

	// 40 MHz register clock
	always #12.5 ref_clk = ~ref_clk;

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s exp %h got %h", nm, exp, seen);
		end
	endtask : chk

	// Strobe held for exactly one taking edge; ends on that edge
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge ref_clk);
		reg_wr <= 1'h0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'h0;
		#1 d = reg_rdata;
	endtask : rd

	// Covers the two sync flops plus the registered pad stage
	task automatic gap;
		repeat (4) @(posedge ref_clk);
		#1;
	endtask : gap

	task automatic chkrst;
		for (int i = 0; i < 6; i++) begin
			rd(rst_ad[i]);
			chk(d, rst_v[i], "reset");
		end
	endtask : chkrst

	task automatic close_out;
		if (failures == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : close_out

	// Watchdog against a stuck run
	initial begin
		#2000000;
		failures++;
		close_out;
	end

	initial begin
		{reset_n, reg_wr, reg_rd, spi_mode, spi_data_out, spi_data_oe, a_en, a_lvl, s_en, s_lvl} = '0;
		{irq_level, pdm_clock_output, pri_dout, pri_second_data_output, sec_dout, sec_second_data_output} = '0;
		{sec_bitclk, sec_framesync, general_clock_output, muxed_dout, chain_out, in_pin_c, in_pin_d} = '0;
		{pri_din_pin, bitclk_pin, framesync_pin, reg_addr, reg_wdata, ref_clk} = '0;
		failures = 0;
		tests_run = 0;
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'h1;
		chkrst;
		// Every drive code at both levels, reserved ones included
		for (int v = 0; v < 2; v++) begin
			wr(8'h0e, v ? 8'ha0 : 8'h00);
			for (int i = 0; i < 8; i++) begin
				wr(8'h0a, {4'h2, 1'h0, i[2:0]});
				gap;
				chk(bidir_pin_a_oe_n, drv_oe[v][i], "a_drv");
				chk(bidir_pin_a_pull_up, (v == 1) && (i == 2), "a_pu");
				chk(bidir_pin_a_pull_dn, (v == 0) && (i == 4), "a_pd");
			end
		end
		wr(8'h0a, 8'h21);
		wr(8'h0c, 8'h21);
		gap;
		chk(bidir_pin_a_out, 1'h1, "a_val");
		chk(out_pin_b_out, 1'h1, "b_val");
		wr(8'h0a, 8'he1);
		gap;
		chk(bidir_pin_a_oe_n, 1'h1, "a_rsv");
		// Audio role drives even with the high-impedance style
		wr(8'h0a, 8'h50);
		pri_dout <= 1'h1;
		gap;
		chk(bidir_pin_a_out, 1'h1, "a_aud");
		chk(bidir_pin_a_oe_n, 1'h0, "a_aud_oe");
		// Peripheral mode overrides function and drive fields
		@(posedge ref_clk);
		spi_mode <= 1'h1;
		spi_data_oe <= 1'h1;
		gap;
		chk(out_pin_b_out, 1'h0, "spi");
		chk(out_pin_b_oe_n, 1'h0, "spi_oe");
		@(posedge ref_clk);
		spi_data_out <= 1'h1;
		repeat (2) @(posedge ref_clk);
		spi_data_out <= 1'h0;
		@(posedge ref_clk);
		#1 chk(out_pin_b_out, 1'h1, "b_hold");
		wr(8'h0c, 8'h50);
		spi_mode <= 1'h0;
		gap;
		chk(out_pin_b_keeper_en, 1'h0, "b_keep");
		// Enables, then each source code with only its pin high
		wr(8'h0d, 8'hff);
		rd(8'h0d);
		chk(d, 8'h03, "inen");
		wr(8'h0a, 8'h10);
		wr(8'h10, 8'h10);
		a_en <= 1'h1;
		s_en <= 1'h1;
		for (int k = 1; k < 6; k++) begin
			wr(8'h0f, {1'h0, k < 4 ? k[1:0] : 2'h0, k[2:0], 2'h0});
			{pri_din_pin, s_lvl, in_pin_c, in_pin_d, a_lvl} <= 5'h01 << (k - 1);
			gap;
			chk(primary_second_in, 1'h1, "second_data_input");
			chk(ctrl_clk, k < 4, "cclk");
		end
		wr(8'h0e, 8'h00);
		{in_pin_c, in_pin_d, a_lvl} <= 3'h5;
		gap;
		rd(8'h0e);
		chk(d, 8'h0a, "mon");
		wr(8'h0d, 8'h01);
		gap;
		rd(8'h0e);
		chk(d, 8'h08, "mon_off");
		// Bit clock and frame sync sources, each both ways
		wr(8'h0f, 8'h02);
		{sec_bitclk, framesync_pin} <= 2'h3;
		gap;
		chk(primary_bitclk, 1'h1, "bclk");
		chk(primary_framesync, 1'h1, "fsync");
		wr(8'h0f, 8'h01);
		gap;
		chk(primary_bitclk, 1'h0, "bclk_pin");
		chk(primary_framesync, 1'h0, "fsync_sec");
		// Serial out as general output, then loopback
		wr(8'h10, 8'h29);
		s_en <= 1'h0;
		gap;
		chk(serial_out_out, 1'h1, "so_val");
		chk(serial_out_oe_n, 1'h0, "so_oe");
		wr(8'h10, 8'hd1);
		gap;
		chk(serial_out_out, 1'h1, "so_loop");
		// Another page hides the pin registers
		wr(8'h00, 8'h01);
		wr(8'h0a, 8'h00);
		rd(8'h0a);
		chk(d, 8'h00, "page1");
		wr(8'h00, 8'h00);
		rd(8'h0a);
		chk(d, 8'h10, "page0");
		wr(8'h01, 8'h01);
		chkrst;
		close_out;
	end
endmodule : multifunction_pin_mux_test
`default_nettype wire
